// ===== design/ldc_phase_timer.sv
// Counts a coefficient of time-unit ticks and flags the end of a phase
`timescale 1ns/1ps
`default_nettype none

module ldc_phase_timer #(
  parameter int COEF_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic [COEF_W-1:0] coef_i,
  input wire logic tick_i,
  // Phase end pulse
  output logic done_o
);

  logic [COEF_W-1:0] left_reg;
  logic run_reg;
  logic end_w;

  initial begin
    if (COEF_W < 1) $error("ldc_phase_timer: COEF_W too small");
  end

  // A coefficient of zero ends the phase at the first unit edge
  assign end_w = run_reg && tick_i && (left_reg <= COEF_W'(1));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      left_reg <= '0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      left_reg <= coef_i;
      run_reg <= 1'b1;
      done_o <= 1'b0;
    end else begin
      if (run_reg && tick_i) left_reg <= left_reg - COEF_W'(1);
      if (end_w) run_reg <= 1'b0;
      done_o <= end_w;
    end
  end

endmodule
`default_nettype wire

// ===== design/ldc_tick_div.sv
// Restartable divider making a one-cycle enable pulse per time unit
`timescale 1ns/1ps
`default_nettype none

module ldc_tick_div #(
  parameter int CW = 23
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Control
  input wire logic restart_i,
  input wire logic [CW-1:0] period_i,
  // Enable pulse
  output logic tick_o
);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic last_w;

  initial begin
    if (CW < 2) $error("ldc_tick_div: CW too small");
  end

  // ==========================================
  // Count down; a restart aligns the unit edge to the phase start
  assign last_w = (cnt_reg <= CW'(1));
  assign cnt_next = (restart_i || last_w) ? period_i : cnt_reg - CW'(1);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o <= last_w && !restart_i;
    end
  end

endmodule
`default_nettype wire

// ===== design/ldc_top.sv
// Listen duty cycler: register slave, phase sequencer and end-action logic
`timescale 1ns/1ps
`default_nettype none
`include "ldc_cfg.svh"

// Operation
// - Idle unit: 01=64us, 10=4.1ms, 11=262ms
// - Receive unit uses same code, resets 01
// - Accept on strength, optionally also sync match
// - End 00: stay receiving, stop sequence
// - End 01: after frame/timeout enter mode field
// - End 10: after frame/timeout resume idle
// - End 10: buffer discarded at next receive
// - End field resets 01; 11 reserved
// - Idle time is coefficient times unit
// - Receive time is coefficient times unit
// - Mode codes; read returns mode in effect
module ldc_top #(
  parameter int CW = 23,
  parameter int RES_A_CYC = `LDC_RES_A_CYC,
  parameter int RES_B_CYC = `LDC_RES_B_CYC,
  parameter int RES_C_CYC = `LDC_RES_C_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Receiver datapath indications
  input wire ldc_pkg::ldc_rx_ind_s rx_ind_i,
  // Radio control
  output logic [2:0] op_mode_o,
  output logic rx_on_o,
  output logic fifo_flush_o,
  output logic [2:0] phase_o
);

  // ==========================================
  // Elaboration checks
  initial begin
    if (CW < 2 || CW > 30) $error("ldc_top: CW out of range");
    if (RES_A_CYC < 2 || RES_B_CYC < 2 || RES_C_CYC < 2) $error("ldc_top: unit counts too small");
    if (RES_A_CYC >= (1 << CW) || RES_B_CYC >= (1 << CW) || RES_C_CYC >= (1 << CW)) begin
      $error("ldc_top: unit counts exceed CW");
    end
  end

  // ==========================================
  // Register state
  logic enable_reg;
  logic [2:0] mode_reg;
  logic [1:0] idle_sel_reg;
  logic [1:0] rx_sel_reg;
  logic crit_reg;
  logic [1:0] end_reg;
  logic [7:0] idle_coef_reg;
  logic [7:0] rx_coef_reg;
  logic [2:0] stop_mode_reg;
  ldc_pkg::ldc_state_e state_reg;
  ldc_pkg::ldc_state_e state_next;

  // ==========================================
  // Bus decode
  logic req_w;
  logic acc_w;
  logic wr_w;
  logic idx_ok_w;
  logic [5:0] idx_w;
  logic sel_opm_w;
  logic sel_l1_w;
  logic sel_ic_w;
  logic sel_rc_w;
  logic sel_st_w;
  logic [7:0] wbyte_w;
  logic [7:0] rd_byte_w;

  assign req_w = avs_read_i || avs_write_i;
  // First cycle of a request: read data is prepared, the slave answers next cycle
  assign acc_w = req_w && avs_waitrequest_o;
  // Writes land at the edge where waitrequest is seen low
  assign wr_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign idx_ok_w = (avs_address_i[1:0] == 2'h0);
  assign idx_w = avs_address_i[7:2];
  assign sel_opm_w = idx_ok_w && (idx_w == `LDC_IDX_OPMODE);
  assign sel_l1_w = idx_ok_w && (idx_w == `LDC_IDX_LISTEN1);
  assign sel_ic_w = idx_ok_w && (idx_w == `LDC_IDX_IDLE_COEF);
  assign sel_rc_w = idx_ok_w && (idx_w == `LDC_IDX_RX_COEF);
  assign sel_st_w = idx_ok_w && (idx_w == `LDC_IDX_STATUS);
  assign wbyte_w = avs_writedata_i[7:0];

  // ==========================================
  // Write byte fields
  logic wf_enable_w;
  logic wf_abort_w;
  logic [2:0] wf_mode_w;
  logic [1:0] wf_idle_sel_w;
  logic [1:0] wf_rx_sel_w;
  logic wf_crit_w;
  logic [1:0] wf_end_w;

  assign wf_enable_w = wbyte_w[`LDC_OPM_ENABLE_BIT];
  assign wf_abort_w = wbyte_w[`LDC_OPM_ABORT_BIT];
  assign wf_mode_w = wbyte_w[`LDC_OPM_MODE_LSB +: 3];
  assign wf_idle_sel_w = wbyte_w[`LDC_L1_IDLE_SEL_LSB +: 2];
  assign wf_rx_sel_w = wbyte_w[`LDC_L1_RX_SEL_LSB +: 2];
  assign wf_crit_w = wbyte_w[`LDC_L1_CRIT_BIT];
  assign wf_end_w = wbyte_w[`LDC_L1_END_LSB +: 2];

  // ==========================================
  // Read mux; abort bit always reads zero, mode reads what is in effect
  logic [7:0] opm_rd_w;
  logic [7:0] l1_rd_w;

  assign opm_rd_w = {1'b0, enable_reg, 1'b0, op_mode_o, 2'h0};
  assign l1_rd_w = {idle_sel_reg, rx_sel_reg, crit_reg, end_reg, 1'b0};
  assign rd_byte_w = sel_opm_w ? opm_rd_w :
                     sel_l1_w ? l1_rd_w :
                     sel_ic_w ? idle_coef_reg :
                     sel_rc_w ? rx_coef_reg :
                     sel_st_w ? {5'h00, state_reg} : 8'h00;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= !acc_w;
      if (acc_w) avs_readdata_o <= {24'h000000, rd_byte_w};
    end
  end

  // ==========================================
  // Configuration registers
  logic opm_wr_w;
  logic l1_wr_w;
  logic ic_wr_w;
  logic rc_wr_w;
  logic abort_w;

  assign opm_wr_w = wr_w && sel_opm_w;
  assign l1_wr_w = wr_w && sel_l1_w;
  assign ic_wr_w = wr_w && sel_ic_w;
  assign rc_wr_w = wr_w && sel_rc_w;
  // Abort only means something when written with the enable cleared
  assign abort_w = opm_wr_w && wf_abort_w && !wf_enable_w;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enable_reg <= 1'b0;
      mode_reg <= `LDC_RST_MODE;
      idle_sel_reg <= `LDC_RST_IDLE_SEL;
      rx_sel_reg <= `LDC_RST_RX_SEL;
      crit_reg <= `LDC_RST_CRIT;
      end_reg <= `LDC_RST_END;
      idle_coef_reg <= `LDC_RST_IDLE_COEF;
      rx_coef_reg <= `LDC_RST_RX_COEF;
    end else begin
      if (opm_wr_w) begin
        enable_reg <= wf_enable_w;
        mode_reg <= wf_mode_w;
      end
      if (l1_wr_w) begin
        idle_sel_reg <= wf_idle_sel_w;
        rx_sel_reg <= wf_rx_sel_w;
        crit_reg <= wf_crit_w;
        end_reg <= wf_end_w;
      end
      if (ic_wr_w) idle_coef_reg <= wbyte_w;
      if (rc_wr_w) rx_coef_reg <= wbyte_w;
    end
  end

  // ==========================================
  // Time unit selection; reserved code 00 falls back to the shortest unit
  function automatic logic [CW-1:0] unit_cyc(input logic [1:0] sel);
    logic [CW-1:0] r;
    r = CW'(RES_A_CYC);
    unique case (sel)
      2'h2: r = CW'(RES_B_CYC);
      2'h3: r = CW'(RES_C_CYC);
      default: r = CW'(RES_A_CYC);
    endcase
    return r;
  endfunction

  logic [CW-1:0] idle_unit_w;
  logic [CW-1:0] rx_unit_w;

  assign idle_unit_w = unit_cyc(idle_sel_reg);
  assign rx_unit_w = unit_cyc(rx_sel_reg);

  // ==========================================
  // Phase timing
  logic start_idle_w;
  logic start_rx_w;
  logic start_w;
  logic [CW-1:0] period_w;
  logic [7:0] coef_w;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] div_period_w;
  logic tick_w;
  logic done_w;

  assign start_idle_w = (state_next == ldc_pkg::LDC_ST_IDLE) && (state_reg != ldc_pkg::LDC_ST_IDLE);
  assign start_rx_w = (state_next == ldc_pkg::LDC_ST_RX) && (state_reg != ldc_pkg::LDC_ST_RX);
  assign start_w = start_idle_w || start_rx_w;
  // Unit and coefficient are frozen at phase start so writes never stretch a running phase
  assign period_w = start_idle_w ? idle_unit_w : rx_unit_w;
  assign coef_w = start_idle_w ? idle_coef_reg : rx_coef_reg;
  // Reloads inside a phase reuse the unit frozen at its start, whatever unit the other phase uses
  assign div_period_w = start_w ? period_w : period_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      period_reg <= CW'(RES_A_CYC);
    end else if (start_w) begin
      period_reg <= period_w;
    end
  end

  ldc_tick_div #(
    .CW(CW)
  ) u_div (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .restart_i(start_w),
    .period_i(div_period_w),
    .tick_o(tick_w)
  );

  ldc_phase_timer #(
    .COEF_W(8)
  ) u_timer (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(start_w),
    .coef_i(coef_w),
    .tick_i(tick_w),
    .done_o(done_w)
  );

  // ==========================================
  // Acceptance and end-of-reception events
  logic accept_w;
  logic rx_end_w;

  assign accept_w = rx_ind_i.strength_above && (!crit_reg || rx_ind_i.sync_addr_match);
  assign rx_end_w = rx_ind_i.frame_complete_flag || rx_ind_i.rx_timeout;

  // ==========================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ldc_pkg::LDC_ST_OFF: begin
        if (enable_reg) state_next = ldc_pkg::LDC_ST_IDLE;
      end
      ldc_pkg::LDC_ST_IDLE: begin
        if (done_w) state_next = ldc_pkg::LDC_ST_RX;
      end
      ldc_pkg::LDC_ST_RX: begin
        if (accept_w) begin
          state_next = (end_reg == ldc_pkg::LDC_END_STAY) ? ldc_pkg::LDC_ST_STOP : ldc_pkg::LDC_ST_HOLD;
        end else if (done_w) begin
          state_next = ldc_pkg::LDC_ST_IDLE;
        end
      end
      ldc_pkg::LDC_ST_HOLD: begin
        if (rx_end_w) begin
          state_next = (end_reg == ldc_pkg::LDC_END_RESUME) ? ldc_pkg::LDC_ST_IDLE : ldc_pkg::LDC_ST_STOP;
        end
      end
      ldc_pkg::LDC_ST_STOP: begin
        state_next = ldc_pkg::LDC_ST_STOP;
      end
      default: state_next = ldc_pkg::LDC_ST_OFF;
    endcase
    // Clearing the enable (with or without abort) always parks the sequencer
    if (!enable_reg || abort_w) state_next = ldc_pkg::LDC_ST_OFF;
  end

  // Mode that takes over once the sequence stops
  logic [2:0] stop_mode_w;
  logic stop_entry_w;

  assign stop_mode_w = (state_reg == ldc_pkg::LDC_ST_HOLD) ? mode_reg : 3'(ldc_pkg::LDC_MODE_RX);
  assign stop_entry_w = (state_next == ldc_pkg::LDC_ST_STOP) && (state_reg != ldc_pkg::LDC_ST_STOP);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= ldc_pkg::LDC_ST_OFF;
      stop_mode_reg <= 3'(ldc_pkg::LDC_MODE_RX);
    end else begin
      state_reg <= state_next;
      if (stop_entry_w) stop_mode_reg <= stop_mode_w;
    end
  end

  // ==========================================
  // Radio control outputs
  logic [2:0] eff_mode_w;
  logic rx_on_w;
  logic flush_w;

  // Receiver follows the mode in effect, so a stay-in-receive stop keeps it powered
  assign rx_on_w = (eff_mode_w == 3'(ldc_pkg::LDC_MODE_RX));
  always_comb begin
    eff_mode_w = mode_reg;
    unique case (state_next)
      ldc_pkg::LDC_ST_IDLE: eff_mode_w = 3'(ldc_pkg::LDC_MODE_SLEEP);
      ldc_pkg::LDC_ST_RX, ldc_pkg::LDC_ST_HOLD: eff_mode_w = 3'(ldc_pkg::LDC_MODE_RX);
      ldc_pkg::LDC_ST_STOP: begin
        eff_mode_w = (state_reg == ldc_pkg::LDC_ST_STOP) ? stop_mode_reg : stop_mode_w;
      end
      default: eff_mode_w = mode_reg;
    endcase
  end
  // Each new receive wake-up under resume drops whatever the buffer still holds
  assign flush_w = start_rx_w && (end_reg == ldc_pkg::LDC_END_RESUME);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      op_mode_o <= `LDC_RST_MODE;
      rx_on_o <= 1'b0;
      fifo_flush_o <= 1'b0;
      phase_o <= 3'(ldc_pkg::LDC_ST_OFF);
    end else begin
      op_mode_o <= eff_mode_w;
      rx_on_o <= rx_on_w;
      fifo_flush_o <= flush_w;
      phase_o <= state_next;
    end
  end

endmodule
`default_nettype wire

// ===== shared/ldc_cfg.svh
// Register map, field positions, reset values and timing constants of the listen duty cycler
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

// ==========================================
// Register indices (byte address = 4 * index)
`define LDC_IDX_OPMODE 6'h01
`define LDC_IDX_LISTEN1 6'h0D
`define LDC_IDX_IDLE_COEF 6'h0E
`define LDC_IDX_RX_COEF 6'h0F
`define LDC_IDX_STATUS 6'h21

// ==========================================
// Field positions
`define LDC_OPM_ENABLE_BIT 6
`define LDC_OPM_ABORT_BIT 5
`define LDC_OPM_MODE_LSB 2
`define LDC_L1_IDLE_SEL_LSB 6
`define LDC_L1_RX_SEL_LSB 4
`define LDC_L1_CRIT_BIT 3
`define LDC_L1_END_LSB 1

// ==========================================
// Reset values
`define LDC_RST_MODE 3'h1
`define LDC_RST_IDLE_SEL 2'h2
`define LDC_RST_RX_SEL 2'h1
`define LDC_RST_CRIT 1'h0
`define LDC_RST_END 2'h1
`define LDC_RST_IDLE_COEF 8'hF5
`define LDC_RST_RX_COEF 8'h20

// ==========================================
// Timing, in ns as printed, and cycle counts derived from the clock period
`define LDC_CLK_NS 50
`define LDC_RES_A_NS 64000
`define LDC_RES_B_NS 4100000
`define LDC_RES_C_NS 262000000
`define LDC_RES_A_CYC (`LDC_RES_A_NS / `LDC_CLK_NS)
`define LDC_RES_B_CYC (`LDC_RES_B_NS / `LDC_CLK_NS)
`define LDC_RES_C_CYC (`LDC_RES_C_NS / `LDC_CLK_NS)

`endif

// ===== shared/ldc_pkg.sv
// Types shared by the listen duty cycler modules
package ldc_pkg;

  // ==========================================
  // Operating modes
  typedef enum logic [2:0] {
    LDC_MODE_SLEEP = 3'h0,
    LDC_MODE_STANDBY = 3'h1,
    LDC_MODE_SYNTH = 3'h2,
    LDC_MODE_TX = 3'h3,
    LDC_MODE_RX = 3'h4
  } ldc_mode_e;

  // ==========================================
  // End actions after acceptance
  typedef enum logic [1:0] {
    LDC_END_STAY = 2'h0,
    LDC_END_TO_MODE = 2'h1,
    LDC_END_RESUME = 2'h2,
    LDC_END_RSVD = 2'h3
  } ldc_end_e;

  // ==========================================
  // Sequencer states, Gray along off-idle-rx-hold-stop
  typedef enum logic [2:0] {
    LDC_ST_OFF = 3'h0,
    LDC_ST_IDLE = 3'h1,
    LDC_ST_RX = 3'h3,
    LDC_ST_HOLD = 3'h2,
    LDC_ST_STOP = 3'h6
  } ldc_state_e;

  // ==========================================
  // Indications from the receiver datapath
  typedef struct packed {
    logic strength_above;
    logic sync_addr_match;
    logic frame_complete_flag;
    logic rx_timeout;
  } ldc_rx_ind_s;

endpackage

// ===== test/ldc_top_asserts.sv
// Concurrent checks on the ports of the listen duty cycler
`timescale 1ns/1ps
`default_nettype none

module ldc_top_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Radio control
  input wire logic [2:0] op_mode_o,
  input wire logic rx_on_o,
  input wire logic fifo_flush_o,
  input wire logic [2:0] phase_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // ==========
  // Bus answer
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one cycle");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  abort_zero_a: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i == 8'h04 |-> !avs_readdata_o[5])
    else $error("abort bit read back as one");

  // ==========
  // Sequencer
  idle_sleep_a: assert property (phase_o == 3'h1 |-> op_mode_o == 3'h0)
    else $error("idle phase not reported as sleep");
  rx_mode_a: assert property (rx_on_o |-> op_mode_o == 3'h4)
    else $error("receiver on outside receive mode");
  rx_on_a: assert property (phase_o inside {3'h3, 3'h2} |-> rx_on_o)
    else $error("receiver off during receive or hold");
  rx_level_a: assert property (op_mode_o == 3'h4 |-> rx_on_o)
    else $error("receive mode without receiver on");
  flush_start_a: assert property (fifo_flush_o |-> phase_o == 3'h3 && $past(phase_o) == 3'h1)
    else $error("flush away from receive start");
  flush_once_a: assert property (fifo_flush_o |=> !fifo_flush_o)
    else $error("flush longer than one cycle");
  off_exit_a: assert property (phase_o == 3'h0 |=> phase_o inside {3'h0, 3'h1})
    else $error("sequence left off other than to idle");
  idle_exit_a: assert property (phase_o == 3'h1 |=> phase_o inside {3'h0, 3'h1, 3'h3})
    else $error("idle left other than to receive");
  hold_exit_a: assert property (phase_o == 3'h2 |=> phase_o inside {3'h0, 3'h1, 3'h2, 3'h6})
    else $error("hold left to a wrong state");
  stop_exit_a: assert property (phase_o == 3'h6 |=> phase_o inside {3'h0, 3'h6})
    else $error("stopped sequence restarted");
endmodule

bind ldc_top ldc_top_asserts i_ldc_top_asserts (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .op_mode_o(op_mode_o),
  .rx_on_o(rx_on_o),
  .fifo_flush_o(fifo_flush_o),
  .phase_o(phase_o)
);

`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the listen duty cycler
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [3:0] be;
    logic [31:0] exp;
  } ldc_row_s;

  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  ldc_pkg::ldc_rx_ind_s rx_ind_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [2:0] op_mode_o;
  logic rx_on_o;
  logic fifo_flush_o;
  logic [2:0] phase_o;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int flush_cnt = 0;
  int u;
  int v;
  logic [31:0] q;

  // Small units keep the 262 ms resolution affordable in simulation
  ldc_top #(.RES_A_CYC(4), .RES_B_CYC(8), .RES_C_CYC(16)) i_ldc_top (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .rx_ind_i(rx_ind_i),
    .op_mode_o(op_mode_o),
    .rx_on_o(rx_on_o),
    .fifo_flush_o(fifo_flush_o),
    .phase_o(phase_o)
  );

  // ==========
  // Register rows: write, address, data, byte enables, read value
  ldc_row_s rows [0:13] = '{
    '{1'h0, 8'h04, 8'h00, 4'hF, 32'h04},
    '{1'h0, 8'h34, 8'h00, 4'hF, 32'h92},
    '{1'h0, 8'h38, 8'h00, 4'hF, 32'hF5},
    '{1'h0, 8'h3C, 8'h00, 4'hF, 32'h20},
    '{1'h0, 8'h84, 8'h00, 4'hF, 32'h00},
    '{1'h0, 8'h40, 8'h00, 4'hF, 32'h00},
    '{1'h0, 8'h35, 8'h00, 4'hF, 32'h00},
    '{1'h1, 8'h38, 8'h03, 4'hF, 32'h00},
    '{1'h1, 8'h38, 8'hFF, 4'hE, 32'h00},
    '{1'h0, 8'h38, 8'h00, 4'hF, 32'h03},
    '{1'h1, 8'h34, 8'hFF, 4'hF, 32'h00},
    '{1'h0, 8'h34, 8'h00, 4'hF, 32'hFE},
    '{1'h1, 8'h40, 8'hFF, 4'hF, 32'h00},
    '{1'h0, 8'h40, 8'h00, 4'hF, 32'h00}
  };

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 50);
    if (n >= 50)
      bad_count++;
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d, 4'hF);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00, 4'hF);
    check(nm, q, e);
  endtask

  task automatic wait_ph(input logic [2:0] ph);
    int k;
    k = 0;
    while (phase_o !== ph && k < 5000) begin
      @(posedge mclk_i);
      k++;
    end
    if (k >= 5000)
      bad_count++;
  endtask

  // Counts the cycles a phase lasts; latency of up to three cycles is allowed
  task automatic span(input logic [2:0] ph, input int lo, input int hi);
    int n;
    n = 0;
    wait_ph(ph);
    while (phase_o === ph && n < 5000) begin
      @(posedge mclk_i);
      n++;
    end
    check("span", n >= lo && n <= hi, 1);
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (fifo_flush_o === 1'h1)
      flush_cnt <= flush_cnt + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  // ==========
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'h0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].addr, rows[i].data, rows[i].be);
      if (!rows[i].wr)
        check("row", q, rows[i].exp);
    end
    wr8(8'h38, 8'h02);
    wr8(8'h3C, 8'h02);
    for (int k = 0; k < 4; k++) begin
      u = (k == 3) ? 16 : (k == 2) ? 8 : 4;
      v = (k == 0) ? 16 : (k == 1) ? 8 : 4;
      wr8(8'h34, {k[1:0], ~k[1:0], 4'h4});
      wr8(8'h04, 8'h44);
      span(3'h1, 2 * u, 2 * u + 3);
      span(3'h3, 2 * v, 2 * v + 3);
      check("idle_mode", op_mode_o, 3'h0);
      wr8(8'h04, 8'h24);
    end
    rx_ind_i <= 4'h8;
    wr8(8'h34, 8'h6C);
    wr8(8'h04, 8'h44);
    span(3'h3, 16, 19);
    rx_ind_i <= 4'hC;
    wait_ph(3'h2);
    check("hold", phase_o, 3'h2);
    check("hold_rx", {rx_on_o, op_mode_o}, 4'hC);
    rx_ind_i <= 4'h2;
    wait_ph(3'h1);
    check("resume", phase_o, 3'h1);
    rx_ind_i <= 4'h8;
    wr8(8'h34, 8'h62);
    wr8(8'h04, 8'h48);
    wait_ph(3'h2);
    rx_ind_i <= 4'h1;
    wait_ph(3'h6);
    check("end_mode", {rx_on_o, op_mode_o}, 4'h2);
    rdc("opmode", 8'h04, 32'h48);
    rdc("status", 8'h84, 32'h06);
    wr8(8'h04, 8'h24);
    rdc("abort", 8'h04, 32'h04);
    rx_ind_i <= 4'h8;
    wr8(8'h34, 8'h60);
    wr8(8'h04, 8'h44);
    wait_ph(3'h6);
    check("stay_rx", {rx_on_o, op_mode_o}, 4'hC);
    repeat (40) @(posedge mclk_i);
    check("stop_held", phase_o, 3'h6);
    wr8(8'h04, 8'h04);
    rdc("off", 8'h84, 32'h00);
    check("flush", flush_cnt, 6);
    reset_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'h0;
    rdc("rst_l1", 8'h34, 32'h92);
    rdc("rst_idle", 8'h38, 32'hF5);
    rdc("rst_rx", 8'h3C, 32'h20);
    check("rst_mode", op_mode_o, 3'h1);
    finish_test();
  end
endmodule

`default_nettype wire
